/* File: core/kmp_pkg.sv */
// Constants and types for the kernel mode protection block.
// Assumes a core that reports every fetch, data access, branch and interrupt
// vector to this block in the same cycle, on the core clock.
package kmp_pkg;
    localparam int          PADDR_W        = 14;
    localparam int          DADDR_W        = 14;
    localparam int          OVL_W          = 16;
    localparam int          BLOCKS         = 16;
    localparam int          BLOCK_SHIFT    = 10;
    localparam int          WIPE_CYCLES    = 16;
    localparam logic [13:0] KERNEL_ENTRY   = 14'h2000;
    localparam logic [13:0] KPROG_LO       = 14'h2001;
    localparam logic [13:0] KPROG_HI       = 14'h3fff;
    localparam logic [15:0] KPOVL_LO       = 16'h000c;
    localparam logic [15:0] KPOVL_HI       = 16'h000f;
    localparam logic [15:0] KENTRY_OVL     = 16'h000f;
    localparam logic [13:0] KDATA_HI       = 14'h17ff;
    localparam logic [15:0] KDOVL          = 16'h000f;
    localparam logic [15:0] RAM_OVL        = 16'h0000;
    localparam logic [4:0]  WIPE_COUNT     = 5'h10;

    typedef enum logic [1:0] {
        USER_MODE,
        KERNEL_MODE,
        KERNEL_NESTED
    } mode_t;
endpackage : kmp_pkg

/* File: core/kernel_mode_protection.sv */
// Kernel mode supervisor: mode tracking, kernel space policing, violation reset.
// Assumes core strobes are synchronous to clock and valid one cycle each.
//
// Notes on behaviour
// R1 - In user mode any access to kernel program, overlay or data space forces a chip reset on the next clock edge.
// R2 - A violation reset raises a wipe strobe that clears sensitive registers and protected memory.
// R3 - Kernel mode is entered only by call, jump or increment to 0x2000 with program overlay 0x000f.
// R4 - In kernel mode a branch to program space outside kernel space returns to user mode; from nesting it returns to kernel mode.
// R5 - In kernel mode emulator bus requests are ignored and never granted.
// R6 - Kernel code takes interrupts except while it marks a sensitive move, when all are held off.
// R7 - Only one nested kernel entry from an interrupt routine is allowed; deeper nesting is refused.
// R8 - An interrupt vectoring to user space while nested triggers the violation reset.
// R9 - A return from an interrupt that preempted kernel code must resume at the saved address and overlay.
// R10 - Kernel firmware may claim 1K-word blocks of internal program and data RAM as kernel space.
// R11 - After any reset the block is in user mode, not nested, with no blocks claimed.
`timescale 1ns/10ps
module kernel_mode_protection
    import kmp_pkg::*;
#(
    parameter int NBLK = BLOCKS
) (
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               clock_enable,
    input  wire logic               fetch_valid,
    input  wire logic [PADDR_W-1:0] fetch_addr,
    input  wire logic [OVL_W-1:0]   program_overlay_select,
    input  wire logic               fetch_is_call,
    input  wire logic               fetch_is_jump,
    input  wire logic               fetch_is_seq,
    input  wire logic               branch_valid,
    input  wire logic [PADDR_W-1:0] branch_addr,
    input  wire logic               data_valid,
    input  wire logic [DADDR_W-1:0] data_addr,
    input  wire logic [OVL_W-1:0]   data_overlay_select,
    input  wire logic               irq_vector_valid,
    input  wire logic [PADDR_W-1:0] irq_vector_addr,
    input  wire logic               rti_valid,
    input  wire logic [PADDR_W-1:0] rti_addr,
    input  wire logic [OVL_W-1:0]   rti_overlay,
    input  wire logic               sensitive_move,
    input  wire logic               claim_we,
    input  wire logic [NBLK-1:0]    claim_prog,
    input  wire logic [NBLK-1:0]    claim_data,
    input  wire logic               emu_bus_req,
    output logic                    emu_bus_grant,
    output logic                    irq_enable,
    output logic                    kernel_mode,
    output logic                    violation_reset,
    output logic                    wipe
);
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        mode_t               mode;
        logic                in_isr;
        logic                saved_valid;
        logic [PADDR_W-1:0]  saved_addr;
        logic [OVL_W-1:0]    saved_ovl;
        logic [NBLK-1:0]     prog_claim;
        logic [NBLK-1:0]     data_claim;
        logic [4:0]          wipe_cnt;
        logic                grant;
        logic                irq_en;
        logic                kmode;
        logic                viol;
        logic                wipe;
    } state_t;

    state_t state;
    state_t next_state;

    // -------------------------------------------------------------------
    // Claim map lookup
    // -------------------------------------------------------------------
    // One bit per 1K block of internal RAM; addresses past the map are never claimed
    function automatic logic claimed(input logic [13:0] addr, input logic [NBLK-1:0] map);
        logic [13:0] idx;
        idx = addr >> BLOCK_SHIFT;
        claimed = (idx < 14'(NBLK)) ? map[idx[$clog2(NBLK)-1:0]] : 1'b0;
    endfunction : claimed

    // -------------------------------------------------------------------
    // Kernel space decode
    // -------------------------------------------------------------------
    logic povl_kernel;
    logic prog_window;
    logic prog_kernel;
    logic data_kernel;
    logic branch_kernel;
    logic vector_kernel;
    logic entry_hit;
    logic in_kernel;
    logic violation;

    always_comb begin
        in_kernel = (state.mode != USER_MODE);
        // Kernel overlay pages are protected whatever the offset within them
        povl_kernel = (program_overlay_select >= KPOVL_LO && program_overlay_select <= KPOVL_HI);
        // Entry word sits just below the window and is policed by entry_hit
        prog_window = (fetch_addr >= KPROG_LO && fetch_addr <= KPROG_HI);
        prog_kernel = prog_window || povl_kernel
            || (program_overlay_select == RAM_OVL && claimed(fetch_addr, state.prog_claim)); // [R1] [R10]
        data_kernel = (data_addr <= KDATA_HI) || (data_overlay_select == KDOVL)
            || (data_overlay_select == RAM_OVL && claimed(data_addr, state.data_claim)); // [R1] [R10]
        // Branch targets count the entry word as kernel space, so a jump back to it stays inside
        branch_kernel = (branch_addr >= KERNEL_ENTRY && branch_addr <= KPROG_HI)
            || povl_kernel
            || (program_overlay_select == RAM_OVL && claimed(branch_addr, state.prog_claim)); // [R4] [R10]
        vector_kernel = (irq_vector_addr >= KERNEL_ENTRY && irq_vector_addr <= KPROG_HI);
        entry_hit = fetch_valid && (fetch_is_call || fetch_is_jump || fetch_is_seq)
            && fetch_addr == KERNEL_ENTRY && program_overlay_select == KENTRY_OVL; // [R3]
        // Several causes may coincide; any one of them is enough
        violation = 1'b0;
        if (!in_kernel && !entry_hit && ((fetch_valid && prog_kernel) || (data_valid && data_kernel))) begin
            violation = 1'b1; // [R1]
        end
        // A user vector while nested would hand preempted kernel context to user code
        if (state.mode == KERNEL_NESTED && irq_vector_valid && !vector_kernel) begin
            violation = 1'b1; // [R8]
        end
        if (entry_hit && state.mode == KERNEL_NESTED) begin
            violation = 1'b1; // [R7]
        end
        // Save is held across modes so a tampered return is caught even after a user branch
        if (rti_valid && state.saved_valid
            && (rti_addr != state.saved_addr || rti_overlay != state.saved_ovl)) begin
            violation = 1'b1; // [R9]
        end
    end

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.viol = 1'b0;
        // Counter keeps running so the wipe outlasts the one-cycle reset pulse
        if (state.wipe_cnt != 5'h00) begin
            next_state.wipe_cnt = state.wipe_cnt - 5'h01;
        end
        if (violation) begin
            // Whole state falls back to reset values while the wipe runs
            next_state = '0;
            next_state.mode = USER_MODE; // [R11]
            next_state.viol = 1'b1; // [R1]
            next_state.wipe_cnt = WIPE_COUNT; // [R2]
        end else begin
            case (state.mode)
                USER_MODE: begin
                    // Claim writes are ignored here so user code cannot widen or drop protection
                    if (entry_hit) begin
                        next_state.mode = KERNEL_MODE; // [R3]
                    end
                end
                KERNEL_MODE: begin
                    // Interrupted address is the fetch that the vector displaced
                    if (irq_vector_valid && !state.saved_valid) begin
                        // Preemption of kernel code is the only way to reach nesting
                        next_state.in_isr = 1'b1;
                        next_state.saved_valid = 1'b1; // [R9]
                        next_state.saved_addr = fetch_addr;
                        next_state.saved_ovl = program_overlay_select;
                    end
                    if (rti_valid && state.saved_valid) begin
                        next_state.saved_valid = 1'b0;
                        next_state.in_isr = 1'b0;
                    end else if (entry_hit && state.in_isr) begin
                        next_state.mode = KERNEL_NESTED; // [R7]
                    end else if (branch_valid && !branch_kernel) begin
                        next_state.mode = USER_MODE; // [R4]
                    end
                    if (claim_we) begin
                        next_state.prog_claim = claim_prog; // [R10]
                        next_state.data_claim = claim_data;
                    end
                end
                KERNEL_NESTED: begin
                    // No save here: the single save slot belongs to the outer kernel context
                    if (branch_valid && !branch_kernel) begin
                        // Nested call returns into the preempted kernel routine
                        next_state.mode = KERNEL_MODE; // [R7]
                    end
                    if (claim_we) begin
                        next_state.prog_claim = claim_prog; // [R10]
                        next_state.data_claim = claim_data;
                    end
                end
                default: next_state.mode = USER_MODE;
            endcase
        end
        next_state.kmode = (next_state.mode != USER_MODE);
        // Grant is judged on the next mode so it drops in the very cycle kernel mode starts
        next_state.grant = emu_bus_req && (next_state.mode == USER_MODE) && !violation; // [R5]
        // Interrupts are held off only for the cycles the firmware flags
        next_state.irq_en = !(next_state.kmode && sensitive_move); // [R6]
        next_state.wipe = (next_state.wipe_cnt != 5'h00); // [R2]
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0; // [R11]
        end else if (clock_enable) begin
            state <= next_state;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Every output is a state flop, never a decode
    assign emu_bus_grant   = state.grant;
    assign irq_enable      = state.irq_en;
    assign kernel_mode     = state.kmode;
    assign violation_reset = state.viol;
    assign wipe            = state.wipe;
endmodule : kernel_mode_protection

/* File: tb/kmp_checker.sv */
// Concurrent checks on the protection block outputs.
// Assumes a bind onto kernel_mode_protection in one clock domain.
`timescale 1ns/10ps
module kmp_checker
    import kmp_pkg::*;
(
    input wire logic               clock,
    input wire logic               resetn,
    input wire logic               clock_enable,
    input wire logic               fetch_valid,
    input wire logic               fetch_is_call,
    input wire logic               fetch_is_jump,
    input wire logic               fetch_is_seq,
    input wire logic [PADDR_W-1:0] fetch_addr,
    input wire logic [OVL_W-1:0]   program_overlay_select,
    input wire logic               branch_valid,
    input wire logic [PADDR_W-1:0] branch_addr,
    input wire logic               data_valid,
    input wire logic [DADDR_W-1:0] data_addr,
    input wire logic               sensitive_move,
    input wire logic               emu_bus_grant,
    input wire logic               irq_enable,
    input wire logic               kernel_mode,
    input wire logic               violation_reset,
    input wire logic               wipe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_entry;
        clock_enable && !kernel_mode && fetch_valid && (fetch_is_call || fetch_is_jump || fetch_is_seq)
            && fetch_addr == KERNEL_ENTRY && program_overlay_select == KENTRY_OVL;
    endsequence
    sequence s_held;
        wipe [*8];
    endsequence
    property p_enter; s_entry |=> kernel_mode && !violation_reset; endproperty
    a_enter: assert property (p_enter) else $error("kernel entry missed");
    property p_exit; clock_enable && kernel_mode && branch_valid && branch_addr < KERNEL_ENTRY |=> !kernel_mode; endproperty
    a_exit: assert property (p_exit) else $error("kernel exit missed");
    property p_user; clock_enable && !kernel_mode && data_valid && data_addr <= KDATA_HI |=> violation_reset; endproperty
    a_user: assert property (p_user) else $error("user access not caught");
    property p_wipe_on; violation_reset |-> wipe; endproperty
    a_wipe_on: assert property (p_wipe_on) else $error("wipe missing");
    property p_wipe_len; $rose(wipe) |-> s_held; endproperty
    a_wipe_len: assert property (p_wipe_len) else $error("wipe too short");
    property p_clear; violation_reset |-> !kernel_mode; endproperty
    a_clear: assert property (p_clear) else $error("mode kept on violation");
    property p_grant; kernel_mode && $past(kernel_mode) |-> !emu_bus_grant; endproperty
    a_grant: assert property (p_grant) else $error("grant in kernel mode");
    property p_irq; kernel_mode && $past(sensitive_move) && $past(clock_enable) |-> !irq_enable; endproperty
    a_irq: assert property (p_irq) else $error("irq open in sensitive move");
endmodule : kmp_checker
bind kernel_mode_protection kmp_checker chk_u (.*);

/* File: tb/core_model.sv */
// Far side stand-in: emulator requests and firmware sensitive-move marks.
// Assumes a random byte from the bench each cycle.
`timescale 1ns/10ps
module core_model (
    input  wire logic       clock,
    input  wire logic [7:0] rnd,
    output logic            emu_bus_req,
    output logic            sensitive_move
);
    initial {emu_bus_req, sensitive_move} = 2'b00;
    always @(posedge clock) begin
        emu_bus_req    <= rnd[0];
        sensitive_move <= rnd[1] & rnd[2];
    end
endmodule : core_model

/* File: tb/tb.sv */
// Bench for kernel mode protection: queued expectations on mode and violation.
// Assumes core_model and the bound checker alongside.
`timescale 1ns/10ps
module tb;
    import kmp_pkg::*;
    logic clock, resetn, clock_enable, fetch_valid, fetch_is_call, fetch_is_jump, fetch_is_seq, branch_valid;
    logic data_valid, irq_vector_valid, rti_valid, sensitive_move, claim_we, emu_bus_req, probe, probe_d;
    logic emu_bus_grant, irq_enable, kernel_mode, violation_reset, wipe;
    logic [13:0] fetch_addr, branch_addr, data_addr, irq_vector_addr, rti_addr;
    logic [15:0] program_overlay_select, data_overlay_select, rti_overlay, claim_prog, claim_data;
    logic [7:0]  rnd = 8'h29;
    logic [1:0]  e, expq[$];
    int          err_count, compares;
    kernel_mode_protection dut_u (.*);
    core_model             core_u (.*);
    // Don't-care marker 2'b11 cannot occur: a violation clears the mode
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic op(input logic [2:0] k, input logic [13:0] a, f, input logic [15:0] o, input logic [1:0] x);
        @(posedge clock);
        {fetch_valid, fetch_is_call, fetch_is_jump, fetch_is_seq} <= {k < 3'h3, k == 3'h0, k == 3'h1, k == 3'h2};
        {branch_valid, data_valid, irq_vector_valid} <= {k == 3'h3, k == 3'h4, k == 3'h5};
        {rti_valid, claim_we, probe} <= {k == 3'h6, k == 3'h7, 1'b1};
        fetch_addr <= (k == 3'h5) ? f : a;
        {branch_addr, data_addr, irq_vector_addr, rti_addr} <= {4{a}};
        {program_overlay_select, data_overlay_select, rti_overlay, claim_prog, claim_data} <= {5{o}};
        expq.push_back(x);
        @(posedge clock);
        {fetch_valid, branch_valid, data_valid, irq_vector_valid, rti_valid, claim_we, probe} <= 7'h0;
    endtask : op
    task automatic final_report;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) rnd <= lfsr(rnd);
    always @(posedge clock) probe_d <= probe;
    always @(negedge clock) if (probe_d) begin
        e = expq.pop_front();
        if (e != 2'b11) begin
            compares++;
            if ({kernel_mode, violation_reset} !== e) begin
                err_count++;
                $display("FAIL t=%0t exp=%h got=%h", $time, e, {kernel_mode, violation_reset});
            end
        end
    end
    initial begin
        #20000;
        err_count++;
        final_report();
    end
    initial begin
        {resetn, fetch_valid, branch_valid, data_valid, irq_vector_valid, rti_valid, claim_we, probe} = 8'h0;
        {fetch_is_call, fetch_is_jump, fetch_is_seq, clock_enable} = 4'h1;
        {fetch_addr, branch_addr, data_addr, irq_vector_addr, rti_addr} = 70'h0;
        {program_overlay_select, data_overlay_select, rti_overlay, claim_prog, claim_data} = 80'h0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) op(3'h4, 14'h1800 | {6'h0, rnd}, 14'h0, 16'h0000, 2'b00);
        op(3'h1, 14'h2000, 14'h0, 16'h0000, 2'b00);
        @(posedge clock) clock_enable <= 1'b0;
        op(3'h4, 14'h0010, 14'h0, 16'h0000, 2'b00);
        clock_enable <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            op(i[2:0], 14'h2000, 14'h0, 16'h000f, 2'b10);
            op(3'h3, 14'h0100, 14'h0, 16'h0000, 2'b00);
        end
        $display("done: entry and exit");
        for (int i = 0; i < 4; i++) begin
            op(i[1] ? 3'h1 + i[2:0] - 3'h2 : 3'h4, i[1] ? 14'h2001 + 14'(i[0]) * 14'h00ff : 14'h0010 + 14'(i[0]) * 14'h18f0,
               14'h0, i[0] ? (i[1] ? 16'h000c : 16'h000f) : 16'h0000, 2'b01);
            repeat (20) @(posedge clock);
        end
        $display("done: user violations");
        op(3'h7, 14'h0, 14'h0, 16'h0040, 2'b00);
        op(3'h4, 14'h1800, 14'h0, 16'h0000, 2'b00);
        op(3'h0, 14'h2000, 14'h0, 16'h000f, 2'b10);
        op(3'h7, 14'h0, 14'h0, 16'h0080, 2'b10);
        op(3'h3, 14'h0100, 14'h0, 16'h0000, 2'b00);
        op(3'h4, 14'h1c00, 14'h0, 16'h0000, 2'b01);
        repeat (20) @(posedge clock);
        op(3'h4, 14'h1c00, 14'h0, 16'h0000, 2'b00);
        $display("done: claims");
        for (int i = 0; i < 3; i++) begin
            op(3'h0, 14'h2000, 14'h0, 16'h000f, 2'b10);
            op(3'h5, 14'h0300, 14'h2345, 16'h000f, 2'b11);
            if (i == 0) op(3'h6, 14'h2346, 14'h0, 16'h000f, 2'b01);
            if (i == 1) op(3'h6, 14'h2345, 14'h0, 16'h000f, 2'b10);
            if (i == 1) op(3'h3, 14'h0100, 14'h0, 16'h0000, 2'b00);
            if (i == 2) op(3'h0, 14'h2000, 14'h0, 16'h000f, 2'b10);
            if (i == 2) op(3'h5, 14'h0400, 14'h2100, 16'h000f, 2'b01);
            repeat (20) @(posedge clock);
        end
        $display("done: interrupts and nesting");
        final_report();
    end
endmodule : tb
